// *** rtl/ulc_uart.sv ***
// Serial port with FIFO control, character format control and line status over APB.
`timescale 1ns/1ps

// Summary of operation
// - FIFO enable bit gates control writes and the level interrupt
// - Enable bit change flushes both FIFOs
// - Bit 1 flushes receive FIFO, self-clearing
// - Bit 2 flushes transmit FIFO, self-clearing
// - Trigger code selects 1, 4, 8, 14
// - Length code selects five to eight bits
// - Stop select: one, two, or one-and-half
// - Parity enable controls generation and check
// - Parity type odd, even, stick one, zero
// - Break bit holds transmit pin low
// - Access bit routes to divisor latches
// - Data ready while receive FIFO not empty
// - Overrun on full FIFO drops new character
// - Status read clears overrun flag
// - Parity mismatch sets flag, status read clears
// - Parity flag belongs to head character
// - Parity flag reported as character reaches head
// - Status register is read-only
// - Level interrupt tracks fill against trigger
// - Each FIFO holds sixteen characters
module ulc_uart (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             txd,
   output logic             rx_level_irq
);
   ulc_pkg::ulc_state_s q;
   ulc_pkg::ulc_state_s next_q;
   logic                acc;
   logic                rd;
   logic                wr;

   // ----------------------------------------------------------------------
   // Helper functions.
   // ----------------------------------------------------------------------
   function automatic logic [4:0] trig_level(input logic [1:0] code);
      case (code)
         2'b00:   trig_level = ulc_pkg::TRIG_L0;
         2'b01:   trig_level = ulc_pkg::TRIG_L1;
         2'b10:   trig_level = ulc_pkg::TRIG_L2;
         default: trig_level = ulc_pkg::TRIG_L3;
      endcase
   endfunction

   // Index of the last data bit: 4 for five bits up to 7 for eight.
   function automatic logic [2:0] last_bit(input logic [7:0] lcr);
      last_bit = {1'b1, lcr[1:0]};
   endfunction

   // Expected parity bit over the active data bits.
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
      logic x;
      x = ^(d & (8'hff >> (2'd3 - lcr[1:0])));
      case (lcr[5:4])
         2'b00:   par_bit = ~x;
         2'b01:   par_bit = x;
         2'b10:   par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Bus decode: a request completes at the edge where pready is seen.
   // ----------------------------------------------------------------------
   assign acc = psel && penable && q.pready;
   assign rd  = acc && !pwrite;
   assign wr  = acc && pwrite;

   // Next-state logic for the whole block.
   always_comb begin
      logic [15:0] dv;
      logic [17:0] half;
      logic [17:0] full;
      logic        new_fen;
      logic        dlab;
      dv      = (q.div == 16'h0000) ? ulc_pkg::DIV_RST : q.div;
      half    = {2'b00, dv};
      full    = {1'b0, dv, 1'b0};
      new_fen = pwdata[ulc_pkg::FCR_EN];
      dlab    = q.lcr[ulc_pkg::LCR_DLAB];
      next_q  = q;

      // One wait state; read data is captured with the ready pulse so a status
      // read returns the flags as they stood before its own clearing effect.
      next_q.pready  = psel && penable && !q.pready;
      next_q.pslverr = 1'b0;
      if (psel && penable && !q.pready) begin
         next_q.prdata = 32'h0000_0000;
         case (paddr)
            ulc_pkg::ADDR_DATA: begin
               if (dlab) begin
                  next_q.prdata[7:0] = q.div[7:0];
               end else begin
                  next_q.prdata[7:0] = q.rxf[q.rx_rp].data;
               end
            end
            ulc_pkg::ADDR_DIVHI: begin
               if (dlab) begin
                  next_q.prdata[7:0] = q.div[15:8];
               end
            end
            ulc_pkg::ADDR_FCR: begin
               // Flush bits read as zero; reserved bits read as zero.
               next_q.prdata[7:0] = {q.trig, 5'b00000, q.fen};
            end
            ulc_pkg::ADDR_LCR: begin
               next_q.prdata[7:0] = q.lcr;
            end
            ulc_pkg::ADDR_LSR: begin
               next_q.prdata[7:0] = {5'b00000, q.pe, q.oe, q.rx_cnt != 5'h00};
            end
            default: begin
               next_q.pslverr = 1'b1;
            end
         endcase
      end

      // Status read clears all error flags together.
      if (rd && paddr == ulc_pkg::ADDR_LSR) begin
         next_q.oe = 1'b0;
         next_q.pe = 1'b0;
      end

      // Receive buffer read pops the head character.
      if (rd && paddr == ulc_pkg::ADDR_DATA && !dlab && q.rx_cnt != 5'h00) begin
         next_q.rx_rp     = q.rx_rp + 4'h1;
         next_q.rx_cnt    = q.rx_cnt - 5'h01;
         next_q.head_done = 1'b0;
      end

      // Register writes; the status address is not in this list.
      // Status writes are ignored.
      if (wr) begin
         case (paddr)
            ulc_pkg::ADDR_DATA: begin
               if (dlab) begin
                  next_q.div[7:0] = pwdata[7:0];
               end else if (q.tx_cnt != ulc_pkg::FIFO_FULL) begin
                  // Sixteen-entry transmit FIFO, full writes dropped.
                  next_q.txf[q.tx_wp] = pwdata[7:0];
                  next_q.tx_wp        = q.tx_wp + 4'h1;
                  next_q.tx_cnt       = q.tx_cnt + 5'h01;
               end
            end
            ulc_pkg::ADDR_DIVHI: begin
               if (dlab) begin
                  next_q.div[15:8] = pwdata[7:0];
               end
            end
            ulc_pkg::ADDR_FCR: begin
               next_q.fen = new_fen;
               // Any enable transition empties both FIFOs.
               if (new_fen != q.fen) begin
                  next_q.rx_wp     = 4'h0;
                  next_q.rx_rp     = 4'h0;
                  next_q.rx_cnt    = 5'h00;
                  next_q.tx_wp     = 4'h0;
                  next_q.tx_rp     = 4'h0;
                  next_q.tx_cnt    = 5'h00;
                  next_q.head_done = 1'b0;
               end
               // Upper bits take effect only with enable set.
               if (new_fen) begin
                  next_q.trig = pwdata[7:6];
                  // Receive flush; the bit is never stored.
                  if (pwdata[ulc_pkg::FCR_RXRST]) begin
                     next_q.rx_wp     = 4'h0;
                     next_q.rx_rp     = 4'h0;
                     next_q.rx_cnt    = 5'h00;
                     next_q.head_done = 1'b0;
                  end
                  // Transmit flush; the bit is never stored.
                  if (pwdata[ulc_pkg::FCR_TXRST]) begin
                     next_q.tx_wp  = 4'h0;
                     next_q.tx_rp  = 4'h0;
                     next_q.tx_cnt = 5'h00;
                  end
               end
            end
            ulc_pkg::ADDR_LCR: begin
               next_q.lcr = pwdata[7:0];
            end
            default: begin
            end
         endcase
      end

      // Receive pin synchroniser; a level counts once the last two stages agree.
      next_q.rx_sync = {q.rx_sync[1:0], rxd};
      if (q.rx_sync[1] == q.rx_sync[2]) begin
         next_q.rx_lvl = q.rx_sync[2];
      end

      // ----------------------------------------------------------------------
      // Transmitter; the timer counts half bit times of div clock cycles.
      // ----------------------------------------------------------------------
      next_q.tx.tmr = (q.tx.tmr == 18'h00000) ? 18'h00000 : q.tx.tmr - 18'h00001;
      case (q.tx.st)
         ulc_pkg::SER_IDLE: begin
            if (next_q.tx_cnt != 5'h00) begin
               next_q.tx.sh  = next_q.txf[next_q.tx_rp];
               next_q.tx_rp  = next_q.tx_rp + 4'h1;
               next_q.tx_cnt = next_q.tx_cnt - 5'h01;
               next_q.tx_line = 1'b0;
               next_q.tx.tmr = full - 18'h00001;
               next_q.tx.st  = ulc_pkg::SER_START;
            end
         end
         ulc_pkg::SER_START: begin
            if (q.tx.tmr == 18'h00000) begin
               next_q.tx_line = q.tx.sh[0];
               next_q.tx.bits = 3'h0;
               next_q.tx.tmr  = full - 18'h00001;
               next_q.tx.st   = ulc_pkg::SER_DATA;
            end
         end
         ulc_pkg::SER_DATA: begin
            if (q.tx.tmr == 18'h00000) begin
               next_q.tx.tmr = full - 18'h00001;
               // Character length sets the last data bit.
               if (q.tx.bits == last_bit(q.lcr)) begin
                  if (q.lcr[ulc_pkg::LCR_PEN]) begin
                     next_q.tx_line = 1'b1;
                     next_q.tx.st   = ulc_pkg::SER_PAR;
                  end else begin
                     next_q.tx_line = 1'b1;
                     next_q.tx.st   = ulc_pkg::SER_STOP;
                  end
               end else begin
                  next_q.tx.bits = q.tx.bits + 3'h1;
                  next_q.tx_line = q.tx.sh[q.tx.bits + 3'h1];
               end
               // Parity bit from the selected type.
               if (q.tx.bits == last_bit(q.lcr) && q.lcr[ulc_pkg::LCR_PEN]) begin
                  next_q.tx_line = par_bit(q.tx.sh, q.lcr);
               end
            end
         end
         ulc_pkg::SER_PAR: begin
            if (q.tx.tmr == 18'h00000) begin
               next_q.tx_line = 1'b1;
               next_q.tx.tmr  = full - 18'h00001;
               next_q.tx.st   = ulc_pkg::SER_STOP;
            end
         end
         ulc_pkg::SER_STOP: begin
            // Stop length: two halves, four halves, or three for 5-bit.
            if (q.tx.tmr == 18'h00000) begin
               next_q.tx.st = ulc_pkg::SER_IDLE;
            end else if (q.tx.bits != 3'h0 && q.lcr[ulc_pkg::LCR_STOP]) begin
               next_q.tx.bits = 3'h0;
               if (q.lcr[1:0] == 2'b00) begin
                  next_q.tx.tmr = q.tx.tmr + half - 18'h00001;
               end else begin
                  next_q.tx.tmr = q.tx.tmr + full - 18'h00001;
               end
            end
         end
         default: begin
            next_q.tx.st = ulc_pkg::SER_IDLE;
         end
      endcase

      // ----------------------------------------------------------------------
      // Receiver; samples each bit in its middle.
      // ----------------------------------------------------------------------
      next_q.rx.tmr = (q.rx.tmr == 18'h00000) ? 18'h00000 : q.rx.tmr - 18'h00001;
      case (q.rx.st)
         ulc_pkg::SER_IDLE: begin
            if (!q.rx_lvl) begin
               next_q.rx.tmr = half - 18'h00001;
               next_q.rx.st  = ulc_pkg::SER_START;
            end
         end
         ulc_pkg::SER_START: begin
            // A start bit that is gone at mid-bit was a glitch.
            if (q.rx.tmr == 18'h00000) begin
               next_q.rx.st   = q.rx_lvl ? ulc_pkg::SER_IDLE : ulc_pkg::SER_DATA;
               next_q.rx.tmr  = full - 18'h00001;
               next_q.rx.bits = 3'h0;
               next_q.rx.sh   = 8'h00;
            end
         end
         ulc_pkg::SER_DATA: begin
            if (q.rx.tmr == 18'h00000) begin
               next_q.rx.sh[q.rx.bits] = q.rx_lvl;
               next_q.rx.bits = q.rx.bits + 3'h1;
               next_q.rx.tmr  = full - 18'h00001;
               if (q.rx.bits == last_bit(q.lcr)) begin
                  next_q.rx.st = q.lcr[ulc_pkg::LCR_PEN] ? ulc_pkg::SER_PAR
                                                         : ulc_pkg::SER_STOP;
                  next_q.rx.bits = 3'h0;
               end
            end
         end
         ulc_pkg::SER_PAR: begin
            // Parity check result travels with the byte.
            if (q.rx.tmr == 18'h00000) begin
               next_q.rx.bits = {2'b00, q.rx_lvl != par_bit(q.rx.sh, q.lcr)};
               next_q.rx.tmr  = full - 18'h00001;
               next_q.rx.st   = ulc_pkg::SER_STOP;
            end
         end
         ulc_pkg::SER_STOP: begin
            if (q.rx.tmr == 18'h00000) begin
               next_q.rx.st = ulc_pkg::SER_IDLE;
               // Full FIFO keeps its contents and flags overrun.
               if (next_q.rx_cnt == ulc_pkg::FIFO_FULL) begin
                  next_q.oe = 1'b1;
               end else begin
                  next_q.rxf[next_q.rx_wp] = {q.rx.bits[0], q.rx.sh};
                  next_q.rx_wp  = next_q.rx_wp + 4'h1;
                  next_q.rx_cnt = next_q.rx_cnt + 5'h01;
               end
            end
         end
         default: begin
            next_q.rx.st = ulc_pkg::SER_IDLE;
         end
      endcase

      // Parity error reported as the byte reaches the head.
      if (next_q.rx_cnt != 5'h00 && !next_q.head_done) begin
         next_q.head_done = 1'b1;
         if (next_q.rxf[next_q.rx_rp].perr) begin
            next_q.pe = 1'b1;
         end
      end

      // Level interrupt follows fill against the trigger.
      next_q.rx_level_irq = next_q.fen && (next_q.rx_cnt >= trig_level(next_q.trig));
      next_q.txd = !next_q.lcr[ulc_pkg::LCR_BRK] && next_q.tx_line;
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q           <= '0;
         q.lcr       <= ulc_pkg::LCR_RST;
         q.div       <= ulc_pkg::DIV_RST;
         q.rx_sync   <= 3'b111;
         q.rx_lvl    <= 1'b1;
         q.rx.st     <= ulc_pkg::SER_IDLE;
         q.tx.st     <= ulc_pkg::SER_IDLE;
         q.tx_line   <= 1'b1;
         q.txd       <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign prdata       = q.prdata;
   assign pready       = q.pready;
   assign pslverr      = q.pslverr;
   assign txd          = q.txd;
   assign rx_level_irq = q.rx_level_irq;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_enable_flush: assert property (
      wr && paddr == ulc_pkg::ADDR_FCR && pwdata[0] != q.fen
      |=> q.tx_cnt == 5'h00 && q.rx_cnt <= 5'h01)
      else $error("FIFOs not flushed on enable change");
   chk_rx_flush: assert property (
      wr && paddr == ulc_pkg::ADDR_FCR && pwdata[0] && pwdata[1]
      |=> q.rx_cnt <= 5'h01)
      else $error("Receive FIFO not flushed");
   chk_tx_flush: assert property (
      wr && paddr == ulc_pkg::ADDR_FCR && pwdata[0] && pwdata[2]
      |=> q.tx_cnt == 5'h00)
      else $error("Transmit FIFO not flushed");
   chk_break_pin: assert property (
      q.lcr[ulc_pkg::LCR_BRK] |-> !txd)
      else $error("Break did not hold the pin low");
   chk_ready_read: assert property (
      psel && penable && !pready && !pwrite && paddr == ulc_pkg::ADDR_LSR
      |=> pready && prdata[0] == $past(q.rx_cnt != 5'h00))
      else $error("Data ready flag wrong");
   chk_overrun_full: assert property (
      $rose(q.oe) |-> $past(q.rx_cnt) == ulc_pkg::FIFO_FULL)
      else $error("Overrun without a full FIFO");
   chk_status_clear: assert property (
      rd && paddr == ulc_pkg::ADDR_LSR && q.rx_cnt < 5'h0f |=> !q.oe)
      else $error("Status read did not clear overrun");
   chk_status_ro: assert property (
      wr && paddr == ulc_pkg::ADDR_LSR && !q.pe && q.rx_cnt == 5'h00 |=> !q.pe)
      else $error("Status write changed a flag");
   chk_divisor_route: assert property (
      wr && paddr == ulc_pkg::ADDR_DATA && q.lcr[ulc_pkg::LCR_DLAB]
      |=> q.div[7:0] == $past(pwdata[7:0]) && q.tx_cnt <= $past(q.tx_cnt))
      else $error("Divisor write not routed");
   chk_level_irq: assert property (
      q.fen && q.rx_cnt >= trig_level(q.trig) ##1 q.rx_cnt == $past(q.rx_cnt)
      |-> rx_level_irq)
      else $error("Level interrupt missing");

   cov_overrun: cover property ($rose(q.oe));
   cov_parity:  cover property ($rose(q.pe));
   cov_break:   cover property (q.lcr[ulc_pkg::LCR_BRK] && q.tx.st != ulc_pkg::SER_IDLE);
   cov_irq:     cover property ($rose(rx_level_irq));
endmodule

// *** shared/ulc_pkg.sv ***
// Shared constants, types and state layout of the serial port line control block.
package ulc_pkg;
   // ----------------------------------------------------------------------
   // Register byte addresses.
   // ----------------------------------------------------------------------
   localparam logic [31:0] ADDR_DATA  = 32'he000c000;
   localparam logic [31:0] ADDR_DIVHI = 32'he000c004;
   localparam logic [31:0] ADDR_FCR   = 32'he000c008;
   localparam logic [31:0] ADDR_LCR   = 32'he000c00c;
   localparam logic [31:0] ADDR_LSR   = 32'he000c014;

   // ----------------------------------------------------------------------
   // Field positions, sizes and reset values.
   // ----------------------------------------------------------------------
   localparam int FCR_EN     = 0;
   localparam int FCR_RXRST  = 1;
   localparam int FCR_TXRST  = 2;
   localparam int LCR_STOP   = 2;
   localparam int LCR_PEN    = 3;
   localparam int LCR_BRK    = 6;
   localparam int LCR_DLAB   = 7;
   localparam logic [4:0]  FIFO_FULL = 5'h10;
   localparam logic [7:0]  LCR_RST   = 8'h00;
   localparam logic [15:0] DIV_RST   = 16'h0001;
   localparam logic [4:0]  TRIG_L0   = 5'h01;
   localparam logic [4:0]  TRIG_L1   = 5'h04;
   localparam logic [4:0]  TRIG_L2   = 5'h08;
   localparam logic [4:0]  TRIG_L3   = 5'h0e;

   // ----------------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------------
   typedef enum logic [4:0] {
      SER_IDLE  = 5'h01,
      SER_START = 5'h02,
      SER_DATA  = 5'h04,
      SER_PAR   = 5'h08,
      SER_STOP  = 5'h10
   } ulc_ser_e;

   typedef struct packed {
      logic       perr;
      logic [7:0] data;
   } ulc_rxent_s;

   typedef struct packed {
      ulc_ser_e    st;
      logic [17:0] tmr;
      logic [2:0]  bits;
      logic [7:0]  sh;
   } ulc_ser_s;

   typedef struct packed {
      logic                  pready;
      logic [31:0]           prdata;
      logic                  pslverr;
      logic                  fen;
      logic [1:0]            trig;
      logic [7:0]            lcr;
      logic [15:0]           div;
      ulc_rxent_s [15:0]     rxf;
      logic [3:0]            rx_wp;
      logic [3:0]            rx_rp;
      logic [4:0]            rx_cnt;
      logic [15:0][7:0]      txf;
      logic [3:0]            tx_wp;
      logic [3:0]            tx_rp;
      logic [4:0]            tx_cnt;
      logic                  oe;
      logic                  pe;
      logic                  head_done;
      logic [2:0]            rx_sync;
      logic                  rx_lvl;
      ulc_ser_s              rx;
      ulc_ser_s              tx;
      logic                  tx_line;
      logic                  txd;
      logic                  rx_level_irq;
   } ulc_state_s;
endpackage

// *** tb/uart_fifo_line_control_test.sv ***
// Self-checking bench for the serial port line control block.
`timescale 1ns/1ps
module uart_fifo_line_control_test;
   logic        pclk, presetn, psel, penable, pwrite, err, ok;
   logic [31:0] paddr, pwdata, prdata, rdv;
   logic        pready, pslverr, rxd, txd, rx_level_irq;
   logic [9:0]  got_bits;
   logic [7:0]  d0, d1;
   int          n_errors, num_checks;

   ulc_uart ulc_uart_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .rx_level_irq(rx_level_irq));
   ulc_peer #(.BITC(8)) ulc_peer_i (.pclk(pclk), .rxd(rxd), .txd(txd));

   // Eight data bits, even parity, one stop; bad flips the parity bit.
   function automatic logic [11:0] frame(input logic [7:0] d, input logic bad);
      return {1'b1, ^d ^ bad, d, 1'b0};
   endfunction

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One transfer; request held until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         finish_test();
      end
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdv, exp);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   // Waits long enough for the stop bit to be sampled and the byte stored.
   task automatic rx_in(input logic [7:0] d, input logic bad);
      ulc_peer_i.send(frame(d, bad), 11);
      repeat (16) @(posedge pclk);
   endtask

   // Free-running bus clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Main sequence.
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      n_errors = 0;
      num_checks = 0;
      void'($urandom(47733));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(ulc_pkg::ADDR_FCR, 32'h0);
      rd(ulc_pkg::ADDR_LCR, 32'h0);
      rd(ulc_pkg::ADDR_LSR, 32'h0);
      rd(32'he000c010, 32'h0);
      chk(err, 32'h1);
      repeat (8) begin
         d0 = $urandom;
         d0[7] = 1'b0;
         wr(ulc_pkg::ADDR_LCR, {24'h0, d0});
         rd(ulc_pkg::ADDR_LCR, {24'h0, d0});
      end
      wr(ulc_pkg::ADDR_LCR, 32'h40);
      @(posedge pclk);
      chk(txd, 32'h0);
      for (int t = 0; t < 4; t++) begin
         wr(ulc_pkg::ADDR_FCR, t * 64 + 1);
         rd(ulc_pkg::ADDR_FCR, t * 64 + 1);
      end
      wr(ulc_pkg::ADDR_FCR, 32'h40);
      rd(ulc_pkg::ADDR_FCR, 32'hc0);
      wr(ulc_pkg::ADDR_FCR, 32'h41);
      wr(ulc_pkg::ADDR_LCR, 32'h80);
      wr(ulc_pkg::ADDR_DATA, 32'h4);
      wr(ulc_pkg::ADDR_DIVHI, 32'h0);
      rd(ulc_pkg::ADDR_DATA, 32'h4);
      wr(ulc_pkg::ADDR_LCR, 32'h1b);
      chk(txd, 32'h1);
      wr(ulc_pkg::ADDR_LSR, 32'hff);
      rd(ulc_pkg::ADDR_LSR, 32'h0);
      d0 = $urandom;
      d1 = $urandom;
      rx_in(d0, 1'b0);
      rx_in(d1, 1'b1);
      rd(ulc_pkg::ADDR_LSR, 32'h1);
      rd(ulc_pkg::ADDR_DATA, {24'h0, d0});
      rd(ulc_pkg::ADDR_LSR, 32'h5);
      rd(ulc_pkg::ADDR_LSR, 32'h1);
      rd(ulc_pkg::ADDR_DATA, {24'h0, d1});
      rd(ulc_pkg::ADDR_LSR, 32'h0);
      repeat (3) rx_in($urandom, 1'b0);
      chk(rx_level_irq, 32'h0);
      rx_in($urandom, 1'b0);
      chk(rx_level_irq, 32'h1);
      wr(ulc_pkg::ADDR_FCR, 32'h43);
      rd(ulc_pkg::ADDR_LSR, 32'h0);
      chk(rx_level_irq, 32'h0);
      d0 = $urandom;
      rx_in(d0, 1'b0);
      repeat (16) rx_in($urandom, 1'b0);
      rd(ulc_pkg::ADDR_LSR, 32'h3);
      rd(ulc_pkg::ADDR_LSR, 32'h1);
      rd(ulc_pkg::ADDR_DATA, {24'h0, d0});
      wr(ulc_pkg::ADDR_FCR, 32'h0);
      rd(ulc_pkg::ADDR_LSR, 32'h0);
      wr(ulc_pkg::ADDR_FCR, 32'h1);
      d0 = $urandom;
      wr(ulc_pkg::ADDR_DATA, {24'h0, d0});
      ulc_peer_i.recv(got_bits, ok);
      chk({ok, got_bits}, {2'b11, ^d0, d0});
      finish_test();
   end
endmodule

// *** tb/ulc_peer.sv ***
// Remote serial peer: drives the receive pin and captures the transmit pin.
`timescale 1ns/1ps
module ulc_peer #(
   parameter int BITC = 8
) (
   input  wire logic pclk,
   output logic      rxd,
   input  wire logic txd
);
   // The line rests at the marking level between frames.
   initial rxd = 1'b1;

   // Frame bits leave LSB first, start bit included, each held BITC clocks.
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         rxd <= f[i];
         repeat (BITC - 1) @(posedge pclk);
      end
   endtask

   // Samples mid-bit after the start edge; ok stays low if no start bit comes.
   task automatic recv(output logic [9:0] b, output logic ok);
      int k;
      k = 0;
      while (txd !== 1'b0 && k < 4000) begin
         @(posedge pclk);
         k++;
      end
      ok = (k < 4000);
      repeat (BITC / 2) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         repeat (BITC) @(posedge pclk);
         b[i] = txd;
      end
   endtask
endmodule
